// ### core/fmac_pkg.sv
// Constants for the fractional / unsigned multiply-accumulate datapath.
// Assumes a 32-bit APB register bus and a 48-bit accumulator format.
package fmac_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int ACC_W    = 48;
    localparam int PROD_W   = 64;
    localparam int ACC_N    = 4;
    localparam int ACC_IW   = 2;

    // ------------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] ADDR_STATUS   = 8'h00;
    localparam logic [7:0] ADDR_OPX      = 8'h04;
    localparam logic [7:0] ADDR_OPY      = 8'h08;
    localparam logic [7:0] ADDR_CMD      = 8'h0C;
    localparam logic [7:0] ADDR_ACC_BASE = 8'h10;
    localparam logic [7:0] ACC_STRIDE    = 8'h08;

    // ------------------------------------------------------------------
    // Status register fields
    // ------------------------------------------------------------------
    localparam int ST_EXT   = 0;
    localparam int ST_V     = 1;
    localparam int ST_Z     = 2;
    localparam int ST_N     = 3;
    localparam int ST_RND   = 4;
    localparam int ST_FI    = 5;
    localparam int ST_SU    = 6;
    localparam int ST_SAT   = 7;
    localparam int ST_PAV   = 8;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ------------------------------------------------------------------
    // Command register fields
    // ------------------------------------------------------------------
    localparam int CMD_SUB  = 0;
    localparam int CMD_WORD = 1;
    localparam int CMD_XHI  = 2;
    localparam int CMD_YHI  = 3;
    localparam int CMD_SCALE = 4;
    localparam int CMD_ACC  = 6;
    localparam int CMD_W    = 8;

    // ------------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [1:0]  MODE_SINT      = 2'h0;
    localparam logic [1:0]  MODE_UINT      = 2'h2;
    localparam logic [1:0]  SCALE_LEFT     = 2'h1;
    localparam logic [1:0]  SCALE_RIGHT    = 2'h3;
    localparam logic [23:0] RND_HALF       = 24'h80_0000;
    localparam logic [31:0] MOST_NEG       = 32'h8000_0000;
    localparam logic [47:0] FRAC_SAT_POS   = 48'h007F_FFFF_FF00;
    localparam logic [47:0] FRAC_SAT_NEG   = 48'hFF80_0000_0000;
    localparam logic [47:0] UINT_SAT_HI    = 48'hFFFF_FFFF_FFFF;
    localparam logic [47:0] UINT_SAT_LO    = 48'h0000_0000_0000;

endpackage

// ### core/fmac_datapath.sv
// Multiply-accumulate datapath for signed-fractional and unsigned-integer
// modes, with its control, operand, command and accumulator registers on APB.
// Assumes an APB3 master on the core clock; one operation per command write except in signed-integer mode.
//
// Summary of operation
// (RQ1) Mode comes from sign/unsigned and fraction/integer bits: 0 sint, 1/3 frac, 2 uint.
// (RQ2) Mode 2 runs unsigned: zero extension, unsigned overflow and saturation.
// (RQ3) Evaluate only if saturation off or sticky flag clear; clear flag on evaluating.
// (RQ4) Fractional word operands: selected half in bits 31:16, zeros below.
// (RQ5) Long-word fractional or unsigned operands are the full 32-bit registers.
// (RQ6) Fractional product is the 64-bit product shifted left once.
// (RQ7) With rounding on, bump bits 63:24 above half, or at half when bit 24 set.
// (RQ8) Fractional bits 71:64 zero for minus-one squared, else copies of bit 63.
// (RQ9) Fractional result is accumulator plus or minus product bits 71:24.
// (RQ10) Fractional overflow sets flags; saturation picks the signed limit by result sign.
// (RQ11) Result goes to accumulator; V copies sticky flag; N bit 47, Z all zero.
// (RQ12) Fractional extension flag clear when bits 47:39 all zeros or all ones.
// (RQ13) Unsigned word operands zero-extend the selected 16-bit half.
// (RQ14) Unsigned product overflow if bits 63:40 nonzero; saturate zero or all ones.
// (RQ15) Unsigned product bits 47:40 cleared before scaling.
// (RQ16) Scale code 0 none, 1 left, 2 reserved none, 3 right with zero fill.
// (RQ17) Unsigned accumulation happens only when the sticky flag is clear after product check.
// (RQ18) Unsigned accumulation overflow sets flags; saturate zero for subtract, ones for add.
// (RQ19) Unsigned extension flag clear when accumulator bits 47:32 are zero.
// (RQ20) Each accumulator keeps a sticky overflow bit that drives the V flag.
// (RQ21) Accumulation overflow means the true result does not fit the 48-bit format.
`timescale 1ns/100ps

module fmac_datapath
    import fmac_pkg::*;
#(
    parameter int ACC_COUNT = fmac_pkg::ACC_N
) (
    input  wire logic                          clk,
    input  wire logic                          rst,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [fmac_pkg::ADDR_W-1:0]   paddr,
    input  wire logic [fmac_pkg::DATA_W-1:0]   pwdata,
    output logic      [fmac_pkg::DATA_W-1:0]   prdata,
    output logic                               pready,
    output logic                               pslverr,
    output logic                               op_done
);
    import fmac_pkg::*;

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------
    logic [7:0]           ctrl_reg;
    logic [3:0]           flags_reg;
    logic [ACC_COUNT-1:0] pav_reg;
    logic [31:0]          opx_reg;
    logic [31:0]          opy_reg;
    logic [CMD_W-1:0]     cmd_reg;
    logic [ACC_W-1:0]     acc_reg [ACC_COUNT];
    logic                 go_reg;
    logic                 done_reg;
    logic [31:0]          prdata_reg;
    logic                 pready_reg;
    logic                 pslverr_reg;

    // ------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------
    wire                  setup     = psel & ~penable;
    wire                  hit_st    = paddr == ADDR_STATUS;
    wire                  hit_x     = paddr == ADDR_OPX;
    wire                  hit_y     = paddr == ADDR_OPY;
    wire                  hit_cmd   = paddr == ADDR_CMD;
    wire [7:0]            acc_off   = paddr - ADDR_ACC_BASE;
    wire [7:0]            acc_span  = 8'(ACC_COUNT * 8);
    wire                  hit_acc   = (paddr >= ADDR_ACC_BASE) && (acc_off < acc_span) && (paddr[1:0] == 2'h0);
    wire [ACC_IW-1:0]     acc_widx  = acc_off[ACC_IW+2:3];
    wire                  acc_hi    = acc_off[2];
    wire                  hit_any   = hit_st | hit_x | hit_y | hit_cmd | hit_acc;
    wire                  wr_fire   = psel & penable & pwrite & pready_reg & ~pslverr_reg;
    wire [ACC_W-1:0]      acc_rd    = acc_reg[acc_widx];
    wire [31:0]           st_word   = {{(24-ACC_COUNT){1'b0}}, pav_reg, ctrl_reg[7:4], flags_reg};
    wire [31:0]           rd_mux    = hit_st  ? st_word :
                                      hit_x   ? opx_reg :
                                      hit_y   ? opy_reg :
                                      hit_cmd ? {24'h0, cmd_reg} :
                                      hit_acc ? (acc_hi ? {16'h0, acc_rd[47:32]} : acc_rd[31:0]) :
                                      32'h0;

    // ------------------------------------------------------------------
    // Operand selection and mode
    // ------------------------------------------------------------------
    wire [1:0]            mode      = {ctrl_reg[ST_SU], ctrl_reg[ST_FI]};    // see RQ1
    wire                  frac_mode = mode[0];
    wire                  uns_mode  = mode == MODE_UINT;                     // see RQ2
    wire                  sat_en    = ctrl_reg[ST_SAT];
    wire                  is_sub    = cmd_reg[CMD_SUB];
    wire                  is_word   = cmd_reg[CMD_WORD];
    wire [1:0]            scale     = cmd_reg[CMD_SCALE+1:CMD_SCALE];
    wire [ACC_IW-1:0]     aidx      = cmd_reg[CMD_ACC+ACC_IW-1:CMD_ACC];
    wire [ACC_W-1:0]      acc_sel   = acc_reg[aidx];
    wire                  pav_sel   = pav_reg[aidx];
    wire [15:0]           x_half    = cmd_reg[CMD_XHI] ? opx_reg[31:16] : opx_reg[15:0];
    wire [15:0]           y_half    = cmd_reg[CMD_YHI] ? opy_reg[31:16] : opy_reg[15:0];
    // Fractional halves go high, unsigned halves are zero-extended.
    wire [31:0]           x_word    = frac_mode ? {x_half, 16'h0000} : {16'h0000, x_half};  // see RQ4 RQ13
    wire [31:0]           y_word    = frac_mode ? {y_half, 16'h0000} : {16'h0000, y_half};  // see RQ4 RQ13
    wire [31:0]           opx       = is_word ? x_word : opx_reg;                           // see RQ5
    wire [31:0]           opy       = is_word ? y_word : opy_reg;                           // see RQ5
    // Sticky overflow with saturation freezes the accumulator.
    wire                  evaluate  = ~sat_en | ~pav_sel;                                   // see RQ3

    // ------------------------------------------------------------------
    // Fractional path
    // ------------------------------------------------------------------
    wire signed [63:0]    sprod     = $signed(opx) * $signed(opy);
    wire [63:0]           fprod     = {sprod[62:0], 1'b0};                                  // see RQ6
    wire                  rnd_up    = ctrl_reg[ST_RND] &&
                                      ((fprod[23:0] > RND_HALF) ||
                                       ((fprod[23:0] == RND_HALF) && fprod[24]));           // see RQ7
    wire [39:0]           fhi       = fprod[63:24] + {39'h0, rnd_up};
    wire                  minus_sq  = (opx == MOST_NEG) && (opy == MOST_NEG);
    wire [7:0]            fext      = minus_sq ? 8'h00 : {8{fhi[39]}};                      // see RQ8
    wire [ACC_W-1:0]      fterm     = {fext, fhi};
    wire [ACC_W-1:0]      fsum      = is_sub ? acc_sel - fterm : acc_sel + fterm;           // see RQ9
    // Signed overflow: operands agree in sign (after negation) but the result does not.
    wire                  f_ovf     = is_sub ? ((acc_sel[47] != fterm[47]) && (fsum[47] != acc_sel[47]))
                                             : ((acc_sel[47] == fterm[47]) && (fsum[47] != acc_sel[47]));  // see RQ21
    wire [ACC_W-1:0]      fsat      = fsum[47] ? FRAC_SAT_POS : FRAC_SAT_NEG;
    wire [ACC_W-1:0]      fres      = (f_ovf && sat_en) ? fsat : fsum;                      // see RQ10

    // ------------------------------------------------------------------
    // Unsigned path
    // ------------------------------------------------------------------
    wire [63:0]           uprod     = opx * opy;
    wire                  u_povf    = |uprod[63:40];                                        // see RQ14
    wire [ACC_W-1:0]      u48       = {8'h00, uprod[39:0]};                                 // see RQ15
    wire [ACC_W-1:0]      uscaled   = (scale == SCALE_LEFT)  ? {7'h00, uprod[39:0], 1'b0} :
                                      (scale == SCALE_RIGHT) ? {8'h00, 1'b0, uprod[39:1]} :
                                      u48;                                                  // see RQ16
    wire [ACC_W:0]        uwide     = is_sub ? {1'b0, acc_sel} - {1'b0, uscaled}
                                             : {1'b0, acc_sel} + {1'b0, uscaled};
    wire                  u_aovf    = uwide[ACC_W];                                         // see RQ21
    wire [ACC_W-1:0]      usat      = is_sub ? UINT_SAT_LO : UINT_SAT_HI;
    // Product overflow skips accumulation; without saturation the accumulator keeps its value.
    wire [ACC_W-1:0]      ures      = u_povf ? (sat_en ? usat : acc_sel) :
                                      (u_aovf && sat_en) ? usat : uwide[ACC_W-1:0];         // see RQ17 RQ18
    wire                  u_ovf     = u_povf | u_aovf;

    // ------------------------------------------------------------------
    // Result and flags
    // ------------------------------------------------------------------
    wire [ACC_W-1:0]      acc_next  = evaluate ? (frac_mode ? fres : ures) : acc_sel;       // see RQ11
    wire                  pav_next  = evaluate ? (frac_mode ? f_ovf : u_ovf) : pav_sel;     // see RQ20
    wire                  n_next    = acc_next[47];
    wire                  z_next    = acc_next == 48'h0;
    wire                  ext_frac  = ~((acc_next[47:39] == 9'h000) || (acc_next[47:39] == 9'h1FF));  // see RQ12
    wire                  ext_uns   = acc_next[47:32] != 16'h0000;                          // see RQ19
    wire [3:0]            flags_nx  = {n_next, z_next, pav_next, frac_mode ? ext_frac : ext_uns};

    // ------------------------------------------------------------------
    // APB slave: zero wait states, registered answer.
    // ------------------------------------------------------------------
    // Read data is latched at the end of the setup cycle. A read whose setup
    // cycle directly follows a command write therefore returns the values from
    // before that operation; software must leave one idle cycle in between.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= 32'h0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~hit_any;
            prdata_reg  <= (setup & ~pwrite) ? rd_mux : prdata_reg;
        end
    end

    // ------------------------------------------------------------------
    // Control, operands and command
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_reg <= CTRL_RESET;
            opx_reg  <= 32'h0;
            opy_reg  <= 32'h0;
            cmd_reg  <= '0;
            go_reg   <= 1'b0;
            done_reg <= 1'b0;
        end else begin
            if (wr_fire && hit_st) ctrl_reg <= {pwdata[ST_SAT:ST_RND], 4'h0};
            if (wr_fire && hit_x) opx_reg <= pwdata;
            if (wr_fire && hit_y) opy_reg <= pwdata;
            if (wr_fire && hit_cmd) cmd_reg <= pwdata[CMD_W-1:0];
            // Signed-integer mode lives elsewhere, so commands are dropped in it.
            go_reg   <= wr_fire && hit_cmd && (mode != MODE_SINT);                           // see RQ1
            done_reg <= go_reg;
        end
    end

    // ------------------------------------------------------------------
    // Flags, sticky bits and accumulators
    // ------------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            flags_reg <= 4'h0;
        end else if (go_reg) begin
            flags_reg <= flags_nx;                                                          // see RQ11
        end else if (wr_fire && hit_st) begin
            flags_reg <= pwdata[3:0];
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < ACC_COUNT; gi++) begin : g_acc
            wire mine = go_reg && (aidx == ACC_IW'(gi));
            wire swr  = wr_fire && hit_acc && (acc_widx == ACC_IW'(gi));
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    acc_reg[gi] <= '0;
                    pav_reg[gi] <= 1'b0;
                end else if (mine) begin
                    acc_reg[gi] <= acc_next;
                    pav_reg[gi] <= pav_next;                                                // see RQ3 RQ20
                end else begin
                    if (swr && acc_hi) acc_reg[gi][47:32] <= pwdata[15:0];
                    if (swr && !acc_hi) acc_reg[gi][31:0] <= pwdata;
                    if (wr_fire && hit_st) pav_reg[gi] <= pwdata[ST_PAV+gi];
                end
            end
        end
    endgenerate

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign op_done = done_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_frozen_on_sticky;
        @(posedge clk) disable iff (rst)
        go_reg && sat_en && pav_sel |=> acc_reg[$past(aidx)] == $past(acc_sel);
    endproperty
    a_frozen_on_sticky: assert property (p_frozen_on_sticky) else $error("accumulator changed while sticky"); // see RQ3

    property p_v_follows_sticky;
        @(posedge clk) disable iff (rst)
        done_reg |-> flags_reg[ST_V] == pav_reg[aidx];
    endproperty
    a_v_follows_sticky: assert property (p_v_follows_sticky) else $error("V flag differs from sticky bit"); // see RQ11

    property p_zn_flags;
        @(posedge clk) disable iff (rst)
        done_reg |-> (flags_reg[ST_Z] == (acc_reg[aidx] == 48'h0)) && (flags_reg[ST_N] == acc_reg[aidx][47]);
    endproperty
    a_zn_flags: assert property (p_zn_flags) else $error("N or Z flag wrong"); // see RQ11

    property p_minus_one_squared;
        @(posedge clk) disable iff (rst)
        go_reg && frac_mode && evaluate && !is_sub && minus_sq && !ctrl_reg[ST_RND] && acc_sel == 48'h0
        |=> acc_reg[$past(aidx)] == 48'h0080_0000_0000;
    endproperty
    a_minus_one_squared: assert property (p_minus_one_squared) else $error("minus one squared wrong"); // see RQ8

    property p_uns_prod_sat;
        @(posedge clk) disable iff (rst)
        go_reg && uns_mode && sat_en && !pav_sel && u_povf
        |=> acc_reg[$past(aidx)] == ($past(is_sub) ? UINT_SAT_LO : UINT_SAT_HI) && pav_reg[$past(aidx)];
    endproperty
    a_uns_prod_sat: assert property (p_uns_prod_sat) else $error("unsigned product saturation wrong"); // see RQ14

    property p_frac_sat;
        @(posedge clk) disable iff (rst)
        go_reg && frac_mode && evaluate && sat_en && f_ovf
        |=> acc_reg[$past(aidx)] == ($past(fsum[47]) ? FRAC_SAT_POS : FRAC_SAT_NEG) && pav_reg[$past(aidx)];
    endproperty
    a_frac_sat: assert property (p_frac_sat) else $error("fractional saturation wrong"); // see RQ10

    property p_uns_ext;
        @(posedge clk) disable iff (rst)
        done_reg && uns_mode |-> flags_reg[ST_EXT] == (acc_reg[aidx][47:32] != 16'h0);
    endproperty
    a_uns_ext: assert property (p_uns_ext) else $error("unsigned extension flag wrong"); // see RQ19

    property p_frac_ext;
        @(posedge clk) disable iff (rst)
        done_reg && frac_mode
        |-> flags_reg[ST_EXT] == !(acc_reg[aidx][47:39] == 9'h000 || acc_reg[aidx][47:39] == 9'h1FF);
    endproperty
    a_frac_ext: assert property (p_frac_ext) else $error("fractional extension flag wrong"); // see RQ12

    property p_sint_ignored;
        @(posedge clk) disable iff (rst)
        wr_fire && hit_cmd && mode == MODE_SINT |=> !go_reg ##1 !done_reg;
    endproperty
    a_sint_ignored: assert property (p_sint_ignored) else $error("command ran in signed integer mode"); // see RQ1

    // An evaluation that does not overflow leaves the sticky bit clear.
    property p_sticky_clears;
        @(posedge clk) disable iff (rst)
        go_reg && evaluate && !(frac_mode ? f_ovf : u_ovf)
        |=> !pav_reg[$past(aidx)];
    endproperty
    a_sticky_clears: assert property (p_sticky_clears) else $error("sticky bit not cleared"); // see RQ3

    property p_uns_prod_hold;
        @(posedge clk) disable iff (rst)
        go_reg && uns_mode && !sat_en && u_povf
        |=> acc_reg[$past(aidx)] == $past(acc_sel) && pav_reg[$past(aidx)];
    endproperty
    a_uns_prod_hold: assert property (p_uns_prod_hold) else $error("product overflow moved accumulator"); // see RQ17

    property p_uns_acc_sat;
        @(posedge clk) disable iff (rst)
        go_reg && uns_mode && evaluate && sat_en && !u_povf && u_aovf
        |=> acc_reg[$past(aidx)] == ($past(is_sub) ? UINT_SAT_LO : UINT_SAT_HI) && pav_reg[$past(aidx)];
    endproperty
    a_uns_acc_sat: assert property (p_uns_acc_sat) else $error("unsigned saturation wrong"); // see RQ18

    // The completion pulse lasts exactly one cycle after each accepted command.
    property p_done_pulse;
        @(posedge clk) disable iff (rst)
        go_reg |=> done_reg ##1 !done_reg;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("completion pulse wrong"); // see RQ11

    // ------------------------------------------------------------------
    // Coverage
    // ------------------------------------------------------------------

    c_frac_overflow: cover property (@(posedge clk) disable iff (rst) go_reg && frac_mode && f_ovf);
    c_uns_prod_ovf: cover property (@(posedge clk) disable iff (rst) go_reg && uns_mode && u_povf);
    c_round_tie: cover property (@(posedge clk) disable iff (rst) go_reg && frac_mode && rnd_up
                                 && fprod[23:0] == RND_HALF);
    c_sticky_freeze: cover property (@(posedge clk) disable iff (rst) go_reg && !evaluate);
    c_uns_acc_ovf: cover property (@(posedge clk) disable iff (rst) go_reg && uns_mode && !u_povf && u_aovf);

endmodule // fmac_datapath

// ### sim/fmac_core_model.sv
// Core-side model: issues register-bus transfers and commands.
// Assumes the datapath shares clk and answers every transfer.
`timescale 1ns/100ps
module fmac_core_model
    import fmac_pkg::*;
(
    input  wire logic                        clk,
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic [fmac_pkg::ADDR_W-1:0]      paddr,
    output logic [fmac_pkg::DATA_W-1:0]      pwdata,
    input  wire logic [fmac_pkg::DATA_W-1:0] prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr,
    input  wire logic                        op_done
);
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end

    // Request stays fixed until pready is sampled high.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_op(input logic [31:0] cmd, output logic done);
        logic [31:0] q;
        logic        e;
        xfer(1'b1, ADDR_CMD, cmd, q, e);
        done = 1'b0;
        for (int n = 0; n < 8; n++) begin
            @(posedge clk);
            if (op_done === 1'b1) done = 1'b1;
        end
    endtask
endmodule // fmac_core_model

// ### sim/tb_frac_unsigned_mac_datapath.sv
// Self-checking bench for the multiply-accumulate datapath.
// Assumes the core model drives the register bus.
`timescale 1ns/100ps
module tb_frac_unsigned_mac_datapath;
    import fmac_pkg::*;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, op_done;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, q;
    logic        e;
    int failures, total_checks, cycles;
    initial clk = 1'b0;
    always #4 clk = ~clk;
    fmac_datapath u_dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_done(op_done));
    fmac_core_model u_core (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .op_done(op_done));
    task automatic close_out();
        if (failures == 0 && total_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            close_out();
        end
    end
    // ------------------------------------------------------------------
    // Shared access and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        u_core.xfer(1'b1, a, d, q, e);
    endtask
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
        u_core.xfer(1'b0, a, 32'h0, q, e);
        chk(name, exp, q);
    endtask
    task automatic acc_chk(input int i, input logic [47:0] exp);
        rd_chk("acc_low", ADDR_ACC_BASE + 8'(i * 8), exp[31:0]);
        rd_chk("acc_high", ADDR_ACC_BASE + 8'(i * 8 + 4), {16'h0, exp[47:32]});
    endtask
    task automatic op(input logic [31:0] x, input logic [31:0] y, input logic [31:0] cmd);
        logic d;
        wr(ADDR_OPX, x);
        wr(ADDR_OPY, y);
        u_core.run_op(cmd, d);
        chk("op_done", 32'h1, {31'h0, d});
    endtask
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_frac();
        wr(ADDR_STATUS, 32'h20);
        op(32'h4000_0000, 32'h4000_0000, 32'h00);
        acc_chk(0, 48'h0020_0000_0000);
        rd_chk("status", ADDR_STATUS, 32'h20);
        op(32'h8000_0000, 32'h8000_0000, 32'h40);
        acc_chk(1, 48'h0080_0000_0000);
        rd_chk("status", ADDR_STATUS, 32'h21);
        op(32'h8000_0000, 32'h8000_0000, 32'h41);
        rd_chk("status", ADDR_STATUS, 32'h24);
        op(32'h0000_4000, 32'h4000_0000, 32'h4A);
        acc_chk(1, 48'h0020_0000_0000);
        wr(ADDR_STATUS, 32'h30);
        op(32'h1, 32'h00C0_0000, 32'h80);
        acc_chk(2, 48'h2);
    endtask
    task automatic t_unsigned();
        wr(ADDR_STATUS, 32'h40);
        op(32'h0003_0005, 32'hFFFF_0007, 32'h86);
        acc_chk(2, 48'h17);
        op(32'h3, 32'h5, 32'hB0);
        acc_chk(2, 48'h1E);
        op(32'h3, 32'h5, 32'h90);
        acc_chk(2, 48'h3C);
        op(32'h3, 32'h5, 32'hA0);
        acc_chk(2, 48'h4B);
        rd_chk("status", ADDR_STATUS, 32'h40);
    endtask
    task automatic t_saturate();
        wr(ADDR_STATUS, 32'hC0);
        op(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hC0);
        acc_chk(3, 48'hFFFF_FFFF_FFFF);
        rd_chk("status", ADDR_STATUS, 32'h8CB);
        op(32'h1, 32'h1, 32'hC1);
        acc_chk(3, 48'hFFFF_FFFF_FFFF);
        wr(ADDR_STATUS, 32'hC0);
        op(32'h1, 32'h1, 32'hC1);
        acc_chk(3, 48'hFFFF_FFFF_FFFE);
        rd_chk("status", ADDR_STATUS, 32'hC9);
        op(32'h1, 32'h2, 32'hC0);
        acc_chk(3, 48'hFFFF_FFFF_FFFF);
        rd_chk("status", ADDR_STATUS, 32'h8CB);
        wr(ADDR_STATUS, 32'h40);
        op(32'hFFFF_FFFF, 32'hFFFF_FFFF, 32'hC1);
        acc_chk(3, 48'hFFFF_FFFF_FFFF);
        rd_chk("status", ADDR_STATUS, 32'h84B);
    endtask
    task automatic t_frac_sat();
        logic d;
        wr(ADDR_STATUS, 32'hA0);
        wr(ADDR_ACC_BASE, 32'hFFFF_FFFF);
        wr(ADDR_ACC_BASE + 8'h04, 32'h7FFF);
        op(32'h4000_0000, 32'h4000_0000, 32'h00);
        acc_chk(0, 48'h007F_FFFF_FF00);
        rd_chk("status", ADDR_STATUS, 32'h1A2);
        wr(ADDR_STATUS, 32'h00);
        u_core.run_op(32'h00, d);
        chk("op_done", 32'h0, {31'h0, d});
        acc_chk(0, 48'h007F_FFFF_FF00);
    endtask
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        rd_chk("status", ADDR_STATUS, 32'h0);
        acc_chk(0, 48'h0);
        t_frac();
        t_unsigned();
        t_saturate();
        t_frac_sat();
        u_core.xfer(1'b0, 8'h30, 32'h0, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        close_out();
    end
endmodule // tb_frac_unsigned_mac_datapath
